// file: logic/dppi_pkg.sv
`default_nettype none
// Shared constants and carriers for the dual parallel pixel input port.
package dppi_pkg;

  // Pin geometry of one colour channel and of the whole input.
  localparam int NUM_CLK = 3;
  localparam int NUM_PORT = 2;
  localparam int NUM_CHAN = 3;
  localparam int NUM_DEN = 2;
  localparam int CHAN_W = 10;
  localparam int COMP_W = 8;
  localparam int COMP_MSB = 9;
  localparam int COMP_LSB = 2;
  localparam int PIX_W = 24;
  localparam int PAIR_W = 48;

  // Channel select codes for the internal remap; the spare code falls back.
  localparam logic [1:0] CH_SEL_A = 2'h0;
  localparam logic [1:0] CH_SEL_B = 2'h1;
  localparam logic [1:0] CH_SEL_C = 2'h2;
  localparam logic [1:0] CH_SEL_SPARE = 2'h3;

  // Port indices.
  localparam int PORT_FIRST = 0;
  localparam int PORT_SECOND = 1;

  // Pins of one port: channels A, B, C at indices 0, 1, 2, then syncs.
  typedef struct packed {
    logic [NUM_CHAN-1:0][CHAN_W-1:0] chan;
    logic vsync;
    logic hsync;
  } dppi_port_pins_type;

  // Everything sampled by one port clock edge.
  typedef struct packed {
    dppi_port_pins_type [NUM_PORT-1:0] port;
    logic [NUM_DEN-1:0] den;
  } dppi_pins_type;

  // Static configuration; change it only while the source is idle.
  typedef struct packed {
    logic combined;
    logic [NUM_CLK-1:0] clk_fall;
    logic [NUM_CLK-1:0][NUM_PORT-1:0] clk_assoc;
    logic [NUM_DEN-1:0][NUM_PORT-1:0] den_assoc;
    logic [NUM_PORT-1:0] vsync_other;
    logic [NUM_PORT-1:0] hsync_other;
    logic [NUM_PORT-1:0][NUM_CHAN-1:0][1:0] chan_map;
  } dppi_cfg_type;

  // One stored pixel (or pixel pair) with boundary marks.
  typedef struct packed {
    logic valid;
    logic frame_start;
    logic line_start;
    logic [PAIR_W-1:0] data;
  } dppi_pix_type;

endpackage : dppi_pkg
`default_nettype wire

// file: logic/dppi_capture.sv
`timescale 1ns/1ns
`default_nettype none
module dppi_capture
  import dppi_pkg::*;
(
  input wire logic pix_clk_i,
  input wire logic fall_i,
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire dppi_pins_type pins_i,
  output logic evt_o,
  output dppi_pins_type word_o
);

  // Edge choice is a static inversion of the port clock.
  wire logic cap_clk;
  dppi_pins_type pin_q;
  logic tog_q;
  logic tog_s1_q;
  logic tog_s2_q;
  logic tog_s3_q;
  wire logic tog_edge;

  assign cap_clk = pix_clk_i ^ fall_i; // R10

  // Link side: hold the sample and flip the toggle on every selected edge.
  always_ff @(posedge cap_clk or posedge rst_i)
  begin
    if (rst_i)
    begin
      pin_q <= '0;
      tog_q <= 1'b0;
    end
    else
    begin
      pin_q <= pins_i; // R9
      tog_q <= ~tog_q;
    end
  end

  // System side: the toggle crosses by two flops; a third finds its edge.
  // The held word is stable for a whole port clock period, far longer
  // than the three system cycles the toggle takes to arrive.
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      tog_s1_q <= 1'b0;
      tog_s2_q <= 1'b0;
      tog_s3_q <= 1'b0;
    end
    else if (ce_i)
    begin
      tog_s1_q <= tog_q;
      tog_s2_q <= tog_s1_q;
      tog_s3_q <= tog_s2_q;
    end
  end

  assign tog_edge = tog_s2_q ^ tog_s3_q;

  // Registered event and word, aligned to each other.
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      evt_o <= 1'b0;
      word_o <= '0;
    end
    else if (ce_i)
    begin
      evt_o <= tog_edge;
      if (tog_edge)
      begin
        word_o <= pin_q;
      end
    end
  end

endmodule : dppi_capture
`default_nettype wire

// file: logic/dppi_input_port.sv
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// R1: Each 8-bit component comes from channel lines 9..2, line 9 weighs 128.
// R2: Source holds lines 1 and 0 low; the block ignores them.
// R3: Narrow sources are MSB justified with unused low lines driven to zero.
// R4: Each port works alone, giving 24 bits per sample over three channels.
// R5: Combined mode joins both ports into one 48-bit, two-pixel input.
// R6: Channels A, B, C each route to any internal colour channel.
// R7: Second port vertical sync serves its port, or the first if programmed.
// R8: Second port horizontal sync serves its port, or the first if programmed.
// R9: Three port clocks; each port samples with the clock chosen for it.
// R10: Each port clock captures on rising or falling edge, for either port.
// R11: Two active-high data enables, each assignable to either or both ports.
// R12: Pixels stored only when enabled; sync rises mark line and frame starts.
module dppi_input_port
  import dppi_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire dppi_cfg_type cfg_i,
  input wire logic pixel_port_clock_one_i,
  input wire logic pixel_port_clock_two_i,
  input wire logic pixel_port_clock_three_i,
  input wire logic pixel_data_valid_one_i,
  input wire logic pixel_data_valid_two_i,
  input wire logic [CHAN_W-1:0] first_port_chan_a_i,
  input wire logic [CHAN_W-1:0] first_port_chan_b_i,
  input wire logic [CHAN_W-1:0] first_port_chan_c_i,
  input wire logic first_port_vertical_sync_i,
  input wire logic first_port_horizontal_sync_i,
  input wire logic [CHAN_W-1:0] second_port_chan_a_i,
  input wire logic [CHAN_W-1:0] second_port_chan_b_i,
  input wire logic [CHAN_W-1:0] second_port_chan_c_i,
  input wire logic second_port_vertical_sync_i,
  input wire logic second_port_horizontal_sync_i,
  output dppi_pix_type first_pix_o,
  output dppi_pix_type second_pix_o
);

  wire logic [NUM_CLK-1:0] port_clk;
  dppi_pins_type pins;
  logic [NUM_CLK-1:0] cap_evt;
  dppi_pins_type cap_word [NUM_CLK];
  logic [NUM_PORT-1:0] src_evt;
  dppi_pins_type src_word [NUM_PORT];
  logic [NUM_PORT-1:0] take;
  logic [NUM_PORT-1:0] vs_sel;
  logic [NUM_PORT-1:0] hs_sel;
  logic [NUM_PORT-1:0] den_sel;
  logic [NUM_PORT-1:0][NUM_CHAN-1:0][1:0] map_idx;
  logic [NUM_PORT-1:0][PIX_W-1:0] pix24;
  logic [PIX_W-1:0] pair_hi;
  logic [NUM_PORT-1:0] vs_prev_q;
  logic [NUM_PORT-1:0] hs_prev_q;
  dppi_pix_type pix_q [NUM_PORT];
  dppi_pix_type pix_d [NUM_PORT];

  // Gather the pins; channel index 0 is A, 1 is B, 2 is C.
  assign port_clk = {pixel_port_clock_three_i, pixel_port_clock_two_i,
                     pixel_port_clock_one_i};
  assign pins.port[PORT_FIRST].chan[0] = first_port_chan_a_i;
  assign pins.port[PORT_FIRST].chan[1] = first_port_chan_b_i;
  assign pins.port[PORT_FIRST].chan[2] = first_port_chan_c_i;
  assign pins.port[PORT_FIRST].vsync = first_port_vertical_sync_i;
  assign pins.port[PORT_FIRST].hsync = first_port_horizontal_sync_i;
  assign pins.port[PORT_SECOND].chan[0] = second_port_chan_a_i;
  assign pins.port[PORT_SECOND].chan[1] = second_port_chan_b_i;
  assign pins.port[PORT_SECOND].chan[2] = second_port_chan_c_i;
  assign pins.port[PORT_SECOND].vsync = second_port_vertical_sync_i;
  assign pins.port[PORT_SECOND].hsync = second_port_horizontal_sync_i;
  assign pins.den = {pixel_data_valid_two_i, pixel_data_valid_one_i};

  // One capture unit per port clock; each samples every pin on its edge.
  // Capturing all pins per clock costs flops but lets any clock feed any
  // port without a glitch-prone clock multiplexer.
  for (genvar c = 0; c < NUM_CLK; c++)
  begin : g_clk
    dppi_capture u_cap (
      .pix_clk_i(port_clk[c]),
      .fall_i(cfg_i.clk_fall[c]),
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .pins_i(pins),
      .evt_o(cap_evt[c]),
      .word_o(cap_word[c])
    ); // R9
  end

  // Per port: clock choice, sync routing, enable routing and remap.
  for (genvar p = 0; p < NUM_PORT; p++)
  begin : g_port
    localparam int Q = NUM_PORT - 1 - p;

    // Lowest numbered clock associated with this port wins.
    assign src_evt[p] = cfg_i.clk_assoc[0][p] ? cap_evt[0] :
                        cfg_i.clk_assoc[1][p] ? cap_evt[1] :
                        (cfg_i.clk_assoc[2][p] & cap_evt[2]); // R10
    assign src_word[p] = cfg_i.clk_assoc[0][p] ? cap_word[0] :
                         cfg_i.clk_assoc[1][p] ? cap_word[1] :
                         cap_word[2]; // R9

    // In combined mode the second port has no stream of its own.
    assign take[p] = src_evt[p] & ~(cfg_i.combined & (p == PORT_SECOND));

    // Each sync pin serves its own port or, if programmed, the other one.
    assign vs_sel[p] = cfg_i.vsync_other[p] ? src_word[p].port[Q].vsync
                                            : src_word[p].port[p].vsync; // R7
    assign hs_sel[p] = cfg_i.hsync_other[p] ? src_word[p].port[Q].hsync
                                            : src_word[p].port[p].hsync; // R8

    // Each enable pin may belong to either or both ports, active high.
    assign den_sel[p] = |(src_word[p].den & {cfg_i.den_assoc[1][p],
                                             cfg_i.den_assoc[0][p]}); // R11

    // Remap, then take lines 9..2; lines 1..0 never reach the data.
    for (genvar k = 0; k < NUM_CHAN; k++)
    begin : g_chan
      assign map_idx[p][k] = (cfg_i.chan_map[p][k] == CH_SEL_SPARE) ?
                             CH_SEL_A : cfg_i.chan_map[p][k]; // R6
      assign pix24[p][k*COMP_W +: COMP_W] =
        src_word[p].port[p].chan[map_idx[p][k]][COMP_MSB:COMP_LSB]; // R1 R2
    end

    // Next stored pixel and boundary marks for this port.
    always_comb
    begin
      pix_d[p] = pix_q[p];
      pix_d[p].valid = take[p] & den_sel[p]; // R12
      pix_d[p].frame_start = take[p] & vs_sel[p] & ~vs_prev_q[p]; // R12
      pix_d[p].line_start = take[p] & hs_sel[p] & ~hs_prev_q[p]; // R12
      if (take[p] & den_sel[p])
      begin
        if (cfg_i.combined & (p == PORT_FIRST))
        begin
          pix_d[p].data = {pair_hi, pix24[p]}; // R5
        end
        else
        begin
          pix_d[p].data = {{PIX_W{1'b0}}, pix24[p]}; // R4
        end
      end
    end

    // Stored pixel register and sync history; frozen while ce_i is low.
    always_ff @(posedge clk_i or posedge rst_i)
    begin
      if (rst_i)
      begin
        pix_q[p] <= '0;
        vs_prev_q[p] <= 1'b0;
        hs_prev_q[p] <= 1'b0;
      end
      else if (ce_i)
      begin
        pix_q[p] <= pix_d[p];
        if (take[p])
        begin
          vs_prev_q[p] <= vs_sel[p];
          hs_prev_q[p] <= hs_sel[p];
        end
      end
    end
  end

  // Second pixel of a pair: second port pins taken on the first port clock,
  // remapped with the second port's channel map.
  for (genvar k = 0; k < NUM_CHAN; k++)
  begin : g_pair
    assign pair_hi[k*COMP_W +: COMP_W] =
      src_word[PORT_FIRST].port[PORT_SECOND]
        .chan[map_idx[PORT_SECOND][k]][COMP_MSB:COMP_LSB]; // R5 R1
  end

  assign first_pix_o = pix_q[PORT_FIRST];
  assign second_pix_o = pix_q[PORT_SECOND];

  // Checks, all on the system clock; frozen cycles are judged only by a_ce_freeze.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i || !ce_i);

  // Source clock delivered a sample whose routed enable was high.
  sequence s_enabled_sample;
    src_evt[PORT_FIRST] && den_sel[PORT_FIRST];
  endsequence

  a_store_on_enable: assert property ( // R12
    $past(ce_i) && first_pix_o.valid |-> $past(src_evt[PORT_FIRST]
      && den_sel[PORT_FIRST]))
    else $error("pixel stored without an enabled sample");

  a_enabled_stored: assert property ( // R12
    s_enabled_sample |=> first_pix_o.valid)
    else $error("enabled sample was not stored");

  a_pair_upper: assert property ( // R5
    s_enabled_sample and cfg_i.combined |=>
      first_pix_o.data[PAIR_W-1:PIX_W] == $past(pair_hi))
    else $error("second pixel of pair lost");

  a_pair_quiet: assert property ( // R5
    cfg_i.combined && $past(cfg_i.combined) && $past(ce_i)
      |-> !second_pix_o.valid)
    else $error("second port active in combined mode");

  a_split_upper: assert property ( // R4
    s_enabled_sample and !cfg_i.combined |=>
      first_pix_o.data[PAIR_W-1:PIX_W] == '0)
    else $error("upper half not clear in split mode");

  a_frame_mark: assert property ( // R7
    src_evt[PORT_FIRST] && cfg_i.vsync_other[PORT_FIRST] &&
      src_word[PORT_FIRST].port[PORT_SECOND].vsync &&
      !vs_prev_q[PORT_FIRST] |=> first_pix_o.frame_start)
    else $error("routed vertical sync rise not marked");

  a_line_mark: assert property ( // R8
    src_evt[PORT_FIRST] && !cfg_i.hsync_other[PORT_FIRST] &&
      src_word[PORT_FIRST].port[PORT_FIRST].hsync &&
      !hs_prev_q[PORT_FIRST] |=> first_pix_o.line_start)
    else $error("horizontal sync rise not marked");

  a_clock_owner: assert property ( // R10
    src_evt[PORT_SECOND] |-> |(cap_evt & {cfg_i.clk_assoc[2][PORT_SECOND],
      cfg_i.clk_assoc[1][PORT_SECOND], cfg_i.clk_assoc[0][PORT_SECOND]}))
    else $error("port took a sample from an unassociated clock");

  a_den_assoc: assert property ( // R11
    $past(ce_i) && second_pix_o.valid |-> $past(|(src_word[PORT_SECOND].den
      & {cfg_i.den_assoc[1][PORT_SECOND], cfg_i.den_assoc[0][PORT_SECOND]})))
    else $error("stored with no associated enable high");

  a_comp_lines: assert property ( // R1
    s_enabled_sample and (cfg_i.chan_map[PORT_FIRST][0] == CH_SEL_B) |=>
      first_pix_o.data[COMP_W-1:0] == $past(src_word[PORT_FIRST]
        .port[PORT_FIRST].chan[1][COMP_MSB:COMP_LSB]))
    else $error("component not taken from lines 9 to 2");

  // A second port sample that is enabled and not swallowed by pairing.
  sequence s_second_sample;
    src_evt[PORT_SECOND] && den_sel[PORT_SECOND] && !cfg_i.combined;
  endsequence

  // A first port sample whose routed horizontal sync has just risen.
  sequence s_routed_line_rise;
    src_evt[PORT_FIRST] && cfg_i.hsync_other[PORT_FIRST] &&
      src_word[PORT_FIRST].port[PORT_SECOND].hsync && !hs_prev_q[PORT_FIRST];
  endsequence

  a_split_second: assert property ( // R4
    s_second_sample |=> second_pix_o.valid &&
      second_pix_o.data[PAIR_W-1:PIX_W] == '0)
    else $error("second port pixel lost or upper half not clear");

  a_remap_second: assert property ( // R6
    s_second_sample and (cfg_i.chan_map[PORT_SECOND][NUM_CHAN-1] == CH_SEL_A)
      |=> second_pix_o.data[(NUM_CHAN-1)*COMP_W +: COMP_W] ==
        $past(src_word[PORT_SECOND].port[PORT_SECOND].chan[0]
          [COMP_MSB:COMP_LSB]))
    else $error("second port channel not routed as programmed");

  a_spare_code: assert property ( // R6
    s_enabled_sample and (cfg_i.chan_map[PORT_FIRST][1] == CH_SEL_SPARE) |=>
      first_pix_o.data[COMP_W +: COMP_W] == $past(src_word[PORT_FIRST]
        .port[PORT_FIRST].chan[0][COMP_MSB:COMP_LSB]))
    else $error("spare channel code did not fall back to channel A");

  a_vsync_own: assert property ( // R7
    src_evt[PORT_SECOND] && !cfg_i.combined &&
      !cfg_i.vsync_other[PORT_SECOND] &&
      src_word[PORT_SECOND].port[PORT_SECOND].vsync &&
      !vs_prev_q[PORT_SECOND] |=> second_pix_o.frame_start)
    else $error("own vertical sync rise not marked");

  a_hsync_routed: assert property ( // R8
    s_routed_line_rise |=> first_pix_o.line_start)
    else $error("routed horizontal sync rise not marked");

  a_den_first: assert property ( // R11
    src_evt[PORT_FIRST] && src_word[PORT_FIRST].den[1] &&
      cfg_i.den_assoc[1][PORT_FIRST] |=> first_pix_o.valid)
    else $error("enable two assigned to first port was ignored");

  // Data is only rewritten by a stored pixel; marks alone leave it alone.
  a_hold_first: assert property ( // R12
    $past(ce_i) && !first_pix_o.valid |-> $stable(first_pix_o.data))
    else $error("first port data changed without a stored pixel");

  a_hold_second: assert property ( // R12
    $past(ce_i) && !second_pix_o.valid |-> $stable(second_pix_o.data))
    else $error("second port data changed without a stored pixel");

  a_mark_taken: assert property ( // R12
    $past(ce_i) && (second_pix_o.frame_start || second_pix_o.line_start)
      |-> $past(src_evt[PORT_SECOND] && !cfg_i.combined))
    else $error("boundary mark without a taken sample");

  a_pulse_single: assert property ( // R12
    first_pix_o.valid |=> !first_pix_o.valid)
    else $error("stored pixel flag stood for more than one cycle");

  // A frozen cycle must leave every stored output untouched.
  a_ce_freeze: assert property ( // R12
    @(posedge clk_i) disable iff (rst_i)
    !ce_i |=> $stable(first_pix_o) && $stable(second_pix_o))
    else $error("outputs moved while the clock enable was low");

endmodule : dppi_input_port
`default_nettype wire

// file: verif/dppi_source_model.sv
`timescale 1ns/1ns
`default_nettype none
// Video source stand-in: one clock pulse per pixel on the chosen port clock.
// The clocks stand still low between pixels, as a gated source would.
module dppi_source_model
  import dppi_pkg::*;
(
  output logic [NUM_CLK-1:0] pclk_o,
  output var dppi_pins_type pins_o
);
  // Idle state before the first pixel.
  initial
  begin
    pclk_o = '0;
    pins_o = '0;
  end

  // Pins are set half a pulse early and held across both edges.
  // The low-order lines are forced to zero whatever the caller asks.
  task automatic send(input int c, input dppi_pins_type p);
    dppi_pins_type q;
    q = p;
    for (int i = 0; i < NUM_PORT; i++)
      for (int k = 0; k < NUM_CHAN; k++)
        q.port[i].chan[k][1:0] = 2'h0;
    pins_o <= q;
    #16;
    pclk_o[c] <= 1'b1;
    #32;
    pclk_o[c] <= 1'b0;
    #16;
  endtask : send
endmodule : dppi_source_model
`default_nettype wire

// file: verif/dppi_input_port_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module dppi_input_port_tb_top;
  import dppi_pkg::*;
  logic clk_i;
  logic rst_i;
  logic ce_i;
  dppi_cfg_type cfg;
  logic [NUM_CLK-1:0] pclk;
  dppi_pins_type pins;
  dppi_pix_type pix [NUM_PORT];
  dppi_pix_type exp_q [NUM_PORT][$];
  logic [NUM_PORT-1:0] prev_vs;
  logic [NUM_PORT-1:0] prev_hs;
  logic [PAIR_W-1:0] last_data [NUM_PORT];
  int bad_count;
  int num_checks;
  int cycles;

  dppi_source_model src (.pclk_o(pclk), .pins_o(pins));

  dppi_input_port dut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cfg_i(cfg),
    .pixel_port_clock_one_i(pclk[0]), .pixel_port_clock_two_i(pclk[1]),
    .pixel_port_clock_three_i(pclk[2]),
    .pixel_data_valid_one_i(pins.den[0]),
    .pixel_data_valid_two_i(pins.den[1]),
    .first_port_chan_a_i(pins.port[0].chan[0]),
    .first_port_chan_b_i(pins.port[0].chan[1]),
    .first_port_chan_c_i(pins.port[0].chan[2]),
    .first_port_vertical_sync_i(pins.port[0].vsync),
    .first_port_horizontal_sync_i(pins.port[0].hsync),
    .second_port_chan_a_i(pins.port[1].chan[0]),
    .second_port_chan_b_i(pins.port[1].chan[1]),
    .second_port_chan_c_i(pins.port[1].chan[2]),
    .second_port_vertical_sync_i(pins.port[1].vsync),
    .second_port_horizontal_sync_i(pins.port[1].hsync),
    .first_pix_o(pix[0]), .second_pix_o(pix[1]));

  // System clock, 20 ns period.
  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : complete_run

  task automatic fail(input string msg);
    bad_count++;
    $display("Error at %0t: %s", $time, msg);
  endtask : fail

  task automatic cmp_pix(input dppi_pix_type got, input dppi_pix_type exp);
    num_checks++;
    if (got !== exp)
      fail($sformatf("pixel got %h exp %h", got, exp));
  endtask : cmp_pix

  task automatic cmp_cnt(input int got, input int exp);
    num_checks++;
    if (got != exp)
      fail($sformatf("pixel count off by %0d", got - exp));
  endtask : cmp_cnt

  // Reference of one port clock edge: which ports take it and what they store.
  task automatic model(input int c, input dppi_pins_type s);
    int own;
    int sel;
    int vi;
    int hi;
    logic en;
    dppi_pix_type e;
    for (int p = 0; p < NUM_PORT; p++)
    begin
      own = -1;
      for (int k = NUM_CLK - 1; k >= 0; k--)
        if (cfg.clk_assoc[k][p]) own = k;
      if (own != c || (cfg.combined && p == PORT_SECOND)) continue;
      en = (s.den[0] & cfg.den_assoc[0][p]) | (s.den[1] & cfg.den_assoc[1][p]);
      vi = cfg.vsync_other[p] ? 1 - p : p;
      hi = cfg.hsync_other[p] ? 1 - p : p;
      e = '0;
      e.valid = en;
      e.frame_start = s.port[vi].vsync & ~prev_vs[p];
      e.line_start = s.port[hi].hsync & ~prev_hs[p];
      prev_vs[p] = s.port[vi].vsync;
      prev_hs[p] = s.port[hi].hsync;
      for (int k = 0; k < NUM_CHAN; k++)
      begin
        sel = (cfg.chan_map[p][k] == CH_SEL_SPARE) ? 0 : cfg.chan_map[p][k];
        e.data[k*8 +: 8] = s.port[p].chan[sel][COMP_MSB:COMP_LSB];
        if (cfg.combined)
          e.data[PIX_W + k*8 +: 8] = s.port[1].chan[sel][COMP_MSB:COMP_LSB];
      end
      // A sample with its enable low only marks boundaries; data holds.
      if (!en) e.data = last_data[p];
      last_data[p] = e.data;
      if (en | e.frame_start | e.line_start) exp_q[p].push_back(e);
    end
  endtask : model

  // Reset with a new configuration; every port clock pulses once inside it.
  task automatic new_cfg(input dppi_cfg_type n);
    @(posedge clk_i);
    rst_i <= 1'b1;
    ce_i <= 1'b1;
    cfg <= n;
    for (int c = 0; c < NUM_CLK; c++)
      src.send(c, '0);
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    prev_vs = '0;
    prev_hs = '0;
    for (int p = 0; p < NUM_PORT; p++)
    begin
      exp_q[p].delete();
      last_data[p] = '0;
    end
  endtask : new_cfg

  // Outputs are sampled mid-cycle, away from the edge that updates them.
  always @(negedge clk_i)
  begin
    for (int p = 0; p < NUM_PORT; p++)
      if (pix[p].valid === 1'b1 || pix[p].frame_start === 1'b1 ||
          pix[p].line_start === 1'b1)
      begin
        if (exp_q[p].size() == 0)
          fail("output with no sample behind it");
        else
          cmp_pix(pix[p], exp_q[p].pop_front());
      end
  end

  // Hang guard; the whole run needs well under this many cycles.
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      fail("timeout");
      complete_run();
    end
  end

  // A fixed first configuration then random ones, each followed by random traffic on random clocks.
  initial
  begin
    logic [95:0] r;
    dppi_cfg_type n;
    dppi_pins_type s;
    int c;
    dppi_pix_type held [NUM_PORT];
    rst_i = 1'b1;
    ce_i = 1'b1;
    cfg = '0;
    bad_count = 0;
    num_checks = 0;
    cycles = 0;
    void'($urandom(32'h766DF9CA));
    for (int t = 0; t < 16; t++)
    begin
      r = {$urandom, $urandom, $urandom};
      n = r[$bits(dppi_cfg_type)-1:0];
      if (t == 0)
      begin
        n = '0;
        n.clk_assoc[0] = 2'h3;
        n.den_assoc = 4'h9;
        n.chan_map = 12'h924;
      end
      // Keeps both halves of a pixel pair under one map and one enable.
      if (n.combined)
      begin
        n.chan_map[1] = n.chan_map[0];
        n.den_assoc[0][1] = n.den_assoc[0][0];
        n.den_assoc[1][1] = n.den_assoc[1][0];
      end
      new_cfg(n);
      for (int k = 0; k < 24; k++)
      begin
        r = {$urandom, $urandom, $urandom};
        s = r[$bits(dppi_pins_type)-1:0];
        c = $urandom_range(NUM_CLK - 1, 0);
        model(c, s);
        src.send(c, s);
      end
      repeat (20) @(posedge clk_i);
      for (int p = 0; p < NUM_PORT; p++)
        cmp_cnt(exp_q[p].size(), 0);
      // Frozen system side: a sample sent now must not reach the outputs.
      // The next reset raises the enable again and clears the held sample.
      @(negedge clk_i);
      for (int p = 0; p < NUM_PORT; p++)
        held[p] = pix[p];
      @(posedge clk_i);
      ce_i <= 1'b0;
      s.den = 2'h3;
      src.send(c, s);
      repeat (4) @(posedge clk_i);
      @(negedge clk_i);
      for (int p = 0; p < NUM_PORT; p++)
        cmp_pix(pix[p], held[p]);
      $display("test %0d done", t);
    end
    complete_run();
  end
endmodule : dppi_input_port_tb_top
`default_nettype wire
